// [hw/emc_pkg.sv]
// shared constants for the external memory control block
`default_nettype none
package emc_pkg;
    typedef enum logic [1:0] {
        EMC_MEM_ASYNC,
        EMC_MEM_SDRAM,
        EMC_MEM_SYNC
    } emc_mem_t;

    // register byte offsets
    localparam logic [3:0] EMC_OFF_CTRL   = 4'h0;
    localparam logic [3:0] EMC_OFF_SPACE  = 4'h4;
    localparam logic [3:0] EMC_OFF_ACCESS = 4'h8;
    localparam logic [3:0] EMC_OFF_STATUS = 4'hC;

    // control register fields
    localparam int EMC_CTRL_DIV_LSB   = 0;
    localparam int EMC_CTRL_SDPRES    = 2;
    localparam int EMC_CTRL_SELFREF   = 3;
    localparam int EMC_CTRL_GPO       = 4;
    localparam int EMC_CTRL_RDSEL     = 5;
    // space register: two bits of memory type per chip select space
    // access register fields
    localparam int EMC_ACC_WRITE      = 4;
    localparam int EMC_ACC_START      = 5;

    localparam logic [1:0] EMC_DIV_1 = 2'h0;
    localparam logic [1:0] EMC_DIV_2 = 2'h1;
    localparam logic [1:0] EMC_DIV_4 = 2'h2;

    localparam logic [1:0] EMC_STRAP_EXT  = 2'h0;
    localparam logic [1:0] EMC_STRAP_DIV4 = 2'h1;
    localparam logic [1:0] EMC_STRAP_DIV6 = 2'h2;

    localparam logic [31:0] EMC_CTRL_RST  = 32'h00000004;
    localparam logic [7:0]  EMC_SPACE_RST = 8'h00;

    // strobe countdown start; ready is honoured once this many cycles have passed in the strobe state, so the strobe lasts at least this many plus one
    localparam logic [3:0] EMC_STROBE_CYC = 4'h3;
    localparam logic [31:0] EMC_UNMAPPED  = 32'h00000000;
endpackage
`default_nettype wire

// [hw/emc_ctrl.sv]
// external memory control strobes, clocks, chip selects and hold arbitration
//
// The register addresses and the Avalon-MM interface to the registers were decided locally.
`default_nettype none
module emc_ctrl
    import emc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        memif_ext_clock_in_i,
    input  wire logic [1:0]  clock_source_strap_pins_i,
    input  wire logic        host_bus_hold_request_i,
    input  wire logic        async_ready_in_i,
    output logic             host_bus_hold_grant_o,
    output logic             memif_bus_request_out_o,
    output logic             memif_clock_out_full_o,
    output logic             memif_clock_out_divided_o,
    output logic             read_column_strobe_n_o,
    output logic             output_enable_strobe_n_o,
    output logic             write_strobe_n_o,
    output logic             strobes_oe_o,
    output logic             sdram_clock_enable_out_o,
    output logic             fifo_space_output_enable_n_o,
    output logic [3:0]       chip_select_n_o
);
    typedef enum logic [2:0] {
        EMC_IDLE, EMC_SETUP, EMC_STROBE, EMC_HOLD, EMC_GRANT
    } emc_state_t;

    emc_state_t  state_q;
    logic [31:0] ctrl_q;
    logic [7:0]  space_q;
    logic [3:0]  sel_q;
    logic        wr_q;
    logic        pend_q;
    logic [3:0]  cnt_q;
    logic [1:0]  src_q;
    logic        strap_done_q;
    logic [2:0]  pre_q;
    logic        iclk_q;
    logic [1:0]  div_q;
    logic        ack_q;
    logic [31:0] rdata_q;

    function automatic emc_mem_t space_type(input logic [7:0] sp,
                                            input logic [3:0] oh);
        logic [1:0] t;
        t = 2'h0;
        for (int i = 0; i < 4; i++) begin
            if (oh[i]) begin
                t = sp[2*i +: 2];
            end
        end
        return emc_mem_t'(t);
    endfunction

    function automatic logic [3:0] space_onehot(input logic [3:0] top);
        logic [3:0] oh;
        oh = 4'h0;
        oh[top[1:0]] = 1'b1;
        return oh;
    endfunction

    // bus slave: one wait cycle, answer on the second edge
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ack_q             <= 1'b0;
            avs_waitrequest_o <= 1'b1;
        end else begin
            ack_q             <= (avs_read_i | avs_write_i) & ~ack_q;
            avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & ~ack_q);
        end
    end
    assign avs_readdata_o    = rdata_q;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rdata_q <= EMC_UNMAPPED;
        end else if (avs_read_i & ~ack_q) begin
            case (avs_address_i)
                EMC_OFF_CTRL:   rdata_q <= ctrl_q;
                EMC_OFF_SPACE:  rdata_q <= {24'h000000, space_q};
                EMC_OFF_ACCESS: rdata_q <= {26'h0000000, pend_q, wr_q,
                                            sel_q};
                EMC_OFF_STATUS: rdata_q <= {26'h0000000, src_q,
                                            host_bus_hold_grant_o,
                                            memif_bus_request_out_o,
                                            async_ready_in_i,
                                            state_q != EMC_IDLE};
                default:        rdata_q <= EMC_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ctrl_q  <= EMC_CTRL_RST;
            space_q <= EMC_SPACE_RST;
        end else if (avs_write_i & ack_q) begin
            if (avs_address_i == EMC_OFF_CTRL) begin
                ctrl_q <= avs_writedata_i;
            end
            if (avs_address_i == EMC_OFF_SPACE) begin
                space_q <= avs_writedata_i[7:0];
            end
        end
    end

    // access request register; start is held pending until the fsm takes it
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            pend_q <= 1'b0;
            sel_q  <= 4'h1;
            wr_q   <= 1'b0;
        end else if (avs_write_i & ack_q &
                     avs_address_i == EMC_OFF_ACCESS &
                     avs_writedata_i[EMC_ACC_START]) begin
            pend_q <= 1'b1;
            sel_q  <= space_onehot(avs_writedata_i[3:0]);
            wr_q   <= avs_writedata_i[EMC_ACC_WRITE];
        end else if (state_q == EMC_IDLE & pend_q &
                     ~host_bus_hold_request_i) begin
            pend_q <= 1'b0;
        end
    end

    // strap sampled once after reset release
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            strap_done_q <= 1'b0;
            src_q        <= EMC_STRAP_EXT;
        end else if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            src_q <= (clock_source_strap_pins_i == EMC_STRAP_DIV4 ||
                      clock_source_strap_pins_i == EMC_STRAP_DIV6)
                     ? clock_source_strap_pins_i : EMC_STRAP_EXT;
        end
    end

    // interface clock as a toggling level; core/4 and core/6 by prescaler
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            pre_q  <= 3'h0;
            iclk_q <= 1'b0;
        end else if (src_q == EMC_STRAP_EXT) begin
            pre_q  <= 3'h0;
            iclk_q <= memif_ext_clock_in_i;
        end else if (pre_q == ((src_q == EMC_STRAP_DIV4) ? 3'h1 : 3'h2)) begin
            pre_q  <= 3'h0;
            iclk_q <= ~iclk_q;
        end else begin
            pre_q <= pre_q + 3'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            memif_clock_out_full_o <= 1'b0;
        end else begin
            memif_clock_out_full_o <= iclk_q;
        end
    end

    // divider counts rising edges of the interface clock
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            div_q                     <= 2'h0;
            memif_clock_out_divided_o <= 1'b0;
        end else begin
            if (iclk_q & ~memif_clock_out_full_o) begin
                div_q <= div_q + 2'h1;
            end
            case (ctrl_q[EMC_CTRL_DIV_LSB +: 2])
                EMC_DIV_2: memif_clock_out_divided_o <= div_q[0];
                EMC_DIV_4: memif_clock_out_divided_o <= div_q[1];
                default:   memif_clock_out_divided_o <= iclk_q;
            endcase
        end
    end

    // access and hold sequencer
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            state_q <= EMC_IDLE;
            cnt_q   <= 4'h0;
        end else begin
            case (state_q)
                EMC_IDLE: begin
                    // host hold wins over a new access
                    if (host_bus_hold_request_i) begin
                        state_q <= EMC_GRANT;
                    end else if (pend_q) begin
                        state_q <= EMC_SETUP;
                    end
                end
                EMC_SETUP: begin
                    state_q <= EMC_STROBE;
                    cnt_q   <= EMC_STROBE_CYC;
                end
                EMC_STROBE: begin
                    if (cnt_q != 4'h0) begin
                        cnt_q <= cnt_q - 4'h1;
                    // wait on ready for async space
                    end else if (async_ready_in_i ||
                                 space_type(space_q, sel_q) != EMC_MEM_ASYNC)
                    begin
                        state_q <= EMC_HOLD;
                    end
                end
                EMC_HOLD: state_q <= EMC_IDLE;
                EMC_GRANT: begin
                    if (!host_bus_hold_request_i) begin
                        state_q <= EMC_IDLE;
                    end
                end
                default: state_q <= EMC_IDLE;
            endcase
        end
    end

    // pin outputs registered from state
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            host_bus_hold_grant_o        <= 1'b0;
            memif_bus_request_out_o      <= 1'b0;
            read_column_strobe_n_o       <= 1'b1;
            output_enable_strobe_n_o     <= 1'b1;
            write_strobe_n_o             <= 1'b1;
            strobes_oe_o                 <= 1'b1;
            fifo_space_output_enable_n_o <= 1'b1;
            chip_select_n_o              <= 4'hF;
        end else begin
            host_bus_hold_grant_o <= state_q == EMC_GRANT &
                                     host_bus_hold_request_i;
            memif_bus_request_out_o <= pend_q | (state_q != EMC_IDLE &
                                                 state_q != EMC_GRANT);
            strobes_oe_o <= ~(state_q == EMC_GRANT |
                              (state_q == EMC_IDLE &
                               host_bus_hold_request_i));
            read_column_strobe_n_o       <= 1'b1;
            output_enable_strobe_n_o     <= 1'b1;
            write_strobe_n_o             <= 1'b1;
            fifo_space_output_enable_n_o <= 1'b1;
            chip_select_n_o              <= 4'hF;
            if (state_q == EMC_SETUP || state_q == EMC_STROBE) begin
                chip_select_n_o <= ~sel_q;
            end
            if (state_q == EMC_STROBE) begin
                case (space_type(space_q, sel_q))
                    EMC_MEM_SDRAM: begin
                        read_column_strobe_n_o   <= 1'b0;
                        output_enable_strobe_n_o <= 1'b0;
                        write_strobe_n_o         <= ~wr_q;
                    end
                    EMC_MEM_SYNC: begin
                        read_column_strobe_n_o   <=
                            ctrl_q[EMC_CTRL_RDSEL] ? wr_q : 1'b0;
                        output_enable_strobe_n_o <= wr_q;
                        write_strobe_n_o         <= ~wr_q;
                        // fifo enable on space three only
                        fifo_space_output_enable_n_o <= ~(sel_q[3] & ~wr_q);
                    end
                    default: begin
                        read_column_strobe_n_o   <= wr_q;
                        output_enable_strobe_n_o <= wr_q;
                        write_strobe_n_o         <= ~wr_q;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            sdram_clock_enable_out_o <= 1'b1;
        end else if (ctrl_q[EMC_CTRL_SDPRES]) begin
            sdram_clock_enable_out_o <= ~ctrl_q[EMC_CTRL_SELFREF];
        end else begin
            sdram_clock_enable_out_o <= ctrl_q[EMC_CTRL_GPO];
        end
    end

    property p_grant_needs_req;
        @(posedge clk_i) disable iff (!rstn_i)
        host_bus_hold_grant_o |-> $past(host_bus_hold_request_i);
    endproperty
    a_grant_needs_req: assert property (p_grant_needs_req)
        else $error("hold grant without request");

    property p_grant_floats;
        @(posedge clk_i) disable iff (!rstn_i)
        host_bus_hold_grant_o |-> !strobes_oe_o && chip_select_n_o == 4'hF;
    endproperty
    a_grant_floats: assert property (p_grant_floats)
        else $error("bus driven while granted");

    property p_cs_onehot;
        @(posedge clk_i) disable iff (!rstn_i)
        chip_select_n_o != 4'hF |-> $onehot(~chip_select_n_o);
    endproperty
    a_cs_onehot: assert property (p_cs_onehot)
        else $error("chip selects not one-hot");

    property p_fifo_space3;
        @(posedge clk_i) disable iff (!rstn_i)
        !fifo_space_output_enable_n_o |-> !chip_select_n_o[3];
    endproperty
    a_fifo_space3: assert property (p_fifo_space3)
        else $error("fifo enable outside space three");

    property p_full_clock;
        @(posedge clk_i) disable iff (!rstn_i)
        memif_clock_out_full_o == $past(iclk_q);
    endproperty
    a_full_clock: assert property (p_full_clock)
        else $error("full clock not following interface clock");

    property p_ready_wait;
        @(posedge clk_i) disable iff (!rstn_i)
        (state_q == EMC_STROBE && cnt_q == 4'h0 && !async_ready_in_i &&
         space_type(space_q, sel_q) == EMC_MEM_ASYNC)
        |=> state_q == EMC_STROBE;
    endproperty
    a_ready_wait: assert property (p_ready_wait)
        else $error("async strobe ended while not ready");

    property p_cke_gpo;
        @(posedge clk_i) disable iff (!rstn_i)
        !ctrl_q[EMC_CTRL_SDPRES] ##1 !$past(ctrl_q[EMC_CTRL_SDPRES])
        |-> sdram_clock_enable_out_o == $past(ctrl_q[EMC_CTRL_GPO]);
    endproperty
    a_cke_gpo: assert property (p_cke_gpo)
        else $error("clock enable not following general output bit");

    property p_busreq;
        @(posedge clk_i) disable iff (!rstn_i)
        (state_q == EMC_STROBE) |=> memif_bus_request_out_o;
    endproperty
    a_busreq: assert property (p_busreq)
        else $error("bus request low during access");
endmodule
`default_nettype wire

// [testbench/emc_mem_model.sv]
// far-side model: memory ready, host hold request, external clock, monitor
`default_nettype none
module emc_mem_model (
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    input  wire logic [3:0] cs_n_i,
    input  wire logic       rd_n_i,
    input  wire logic       oe_n_i,
    input  wire logic       wr_n_i,
    input  wire logic       fifo_n_i,
    input  wire logic       clear_i,
    input  wire logic [3:0] delay_i,
    input  wire logic       hold_cmd_i,
    output logic            ready_o,
    output logic            hold_req_o,
    output logic            ext_clk_o,
    output logic [3:0]      cs_seen_o,
    output logic [3:0]      low_seen_o,
    output logic [7:0]      strobe_cyc_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic strobe;
    logic ph;
    assign strobe = !rd_n_i || !wr_n_i;
    assign ready_o = !(strobe && strobe_cyc_o < {4'h0, delay_i});
    always @(posedge clk_i) begin
        hold_req_o <= hold_cmd_i;
        ph <= rstn_i ? !ph : 1'b0;
        if (!rstn_i) begin
            ext_clk_o <= 1'b0;
        end else if (ph) begin
            ext_clk_o <= !ext_clk_o;
        end
        if (clear_i) begin
            cs_seen_o <= 4'h0;
            low_seen_o <= 4'h0;
            strobe_cyc_o <= 8'h00;
        end else begin
            cs_seen_o <= cs_seen_o | ~cs_n_i;
            low_seen_o <= low_seen_o | ~{fifo_n_i, wr_n_i, oe_n_i, rd_n_i};
            if (strobe) begin
                strobe_cyc_o <= strobe_cyc_o + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// [testbench/ext_memory_control_arbitration_tb.sv]
// self-checking bench for the external memory control block
`default_nettype none
module ext_memory_control_arbitration_tb;
    import emc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, rstn_i, rd, wr, clear, hold_cmd, cnt_clr, fp, dp;
    logic [3:0] addr, dly, cs_seen, low_seen;
    logic [31:0] wdata, rdata, exp_q[$], msk_q[$], rnd, q;
    logic [1:0] strap;
    logic [7:0] scyc;
    wire [31:0] avs_readdata_o;
    wire avs_waitrequest_o, host_bus_hold_grant_o, memif_bus_request_out_o;
    wire memif_clock_out_full_o, memif_clock_out_divided_o, strobes_oe_o;
    wire read_column_strobe_n_o, output_enable_strobe_n_o, write_strobe_n_o;
    wire sdram_clock_enable_out_o, fifo_space_output_enable_n_o;
    wire [3:0] chip_select_n_o;
    wire ready, hold_req, ext_clk;
    // floated pins read high through their pull-ups
    wire rd_pin = strobes_oe_o ? read_column_strobe_n_o : 1'b1;
    wire oe_pin = strobes_oe_o ? output_enable_strobe_n_o : 1'b1;
    wire wr_pin = strobes_oe_o ? write_strobe_n_o : 1'b1;
    wire [3:0] cs_pin = strobes_oe_o ? chip_select_n_o : 4'hF;
    int mismatches, compares, full_n, div_n, n;
    emc_ctrl dut (.clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .memif_ext_clock_in_i(ext_clk), .clock_source_strap_pins_i(strap),
        .host_bus_hold_request_i(hold_req), .async_ready_in_i(ready),
        .host_bus_hold_grant_o(host_bus_hold_grant_o),
        .memif_bus_request_out_o(memif_bus_request_out_o),
        .memif_clock_out_full_o(memif_clock_out_full_o),
        .memif_clock_out_divided_o(memif_clock_out_divided_o),
        .read_column_strobe_n_o(read_column_strobe_n_o),
        .output_enable_strobe_n_o(output_enable_strobe_n_o),
        .write_strobe_n_o(write_strobe_n_o), .strobes_oe_o(strobes_oe_o),
        .sdram_clock_enable_out_o(sdram_clock_enable_out_o),
        .fifo_space_output_enable_n_o(fifo_space_output_enable_n_o),
        .chip_select_n_o(chip_select_n_o));
    emc_mem_model mem (.clk_i(clk_i), .rstn_i(rstn_i), .cs_n_i(cs_pin),
        .rd_n_i(rd_pin), .oe_n_i(oe_pin), .wr_n_i(wr_pin),
        .fifo_n_i(fifo_space_output_enable_n_o), .clear_i(clear),
        .delay_i(dly), .hold_cmd_i(hold_cmd), .ready_o(ready),
        .hold_req_o(hold_req), .ext_clk_o(ext_clk), .cs_seen_o(cs_seen),
        .low_seen_o(low_seen), .strobe_cyc_o(scyc));
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = !clk_i;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [31:0] ctl(input logic [3:0] f,
                                        input logic [1:0] d);
        return {26'h0, f, d};
    endfunction
    task automatic finish_test();
        if (mismatches == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        addr <= a;
        wdata <= d;
        rd <= !w;
        wr <= w;
        @(posedge clk_i);
        for (n = 0; n < 50 && avs_waitrequest_o !== 1'b0; n++) begin
            @(posedge clk_i);
        end
        // a slave that never answers counts as a mismatch
        chk("waitrequest", 32'h0, 32'(avs_waitrequest_o));
        rd <= 1'b0;
        wr <= 1'b0;
        // one idle edge so the next call does not re-drive in this step
        @(posedge clk_i);
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [31:0] e,
                          input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic pulse_clear();
        clear <= 1'b1;
        @(posedge clk_i);
        clear <= 1'b0;
    endtask
    // read results are matched against notes in order
    always @(posedge clk_i) begin
        if (rd && avs_waitrequest_o === 1'b0 && exp_q.size() > 0) begin
            rdata = exp_q.pop_front();
            q = msk_q.pop_front();
            chk("readdata", rdata & q, avs_readdata_o & q);
        end
        fp <= memif_clock_out_full_o;
        dp <= memif_clock_out_divided_o;
        full_n = cnt_clr ? 0 : full_n + int'(memif_clock_out_full_o && !fp);
        div_n = cnt_clr ? 0 : div_n + int'(memif_clock_out_divided_o && !dp);
    end
    initial begin
        #100000;
        mismatches++;
        finish_test();
    end
    initial begin
        {rd, wr, clear, hold_cmd, cnt_clr, addr, wdata, dly} = '0;
        rstn_i = 1'b0;
        strap = 2'h0;
        rnd = 32'h16452432;
        for (int s = 0; s < 4; s++) begin
            rstn_i <= 1'b0;
            strap <= s[1:0];
            repeat (3) @(posedge clk_i);
            rstn_i <= 1'b1;
            @(posedge clk_i);
            chk("idle_pins", 32'h1FFB, {17'h0, host_bus_hold_grant_o,
                memif_bus_request_out_o, read_column_strobe_n_o,
                output_enable_strobe_n_o, write_strobe_n_o,
                sdram_clock_enable_out_o, chip_select_n_o,
                fifo_space_output_enable_n_o, strobes_oe_o, 3'h3});
            rd_reg(EMC_OFF_CTRL, EMC_CTRL_RST, 32'hFFFFFFFF);
            // strap picks source, unused code falls back to external
            rd_reg(EMC_OFF_STATUS, {26'h0, (s == 3) ? 2'h0 : s[1:0], 4'h0},
                   32'h30);
            bus(1'b1, EMC_OFF_CTRL, ctl(4'h1, 2'(s % 3)));
            cnt_clr <= 1'b1;
            @(posedge clk_i);
            cnt_clr <= 1'b0;
            repeat (120) @(posedge clk_i);
            n = 120 / (s == 2 ? 6 : 4);
            chk("clk_full", 1, 32'(full_n inside {[n - 1 : n + 1]}));
            n = full_n / (1 << (s % 3));
            chk("clk_div", 1, 32'(div_n inside {[n - 1 : n + 1]}));
        end
        bus(1'b1, 4'h2, 32'hFFFFFFFF);
        rd_reg(4'h2, EMC_UNMAPPED, 32'hFFFFFFFF);
        rd_reg(EMC_OFF_CTRL, ctl(4'h1, 2'h0), 32'hFFFFFFFF);
        for (int t = 0; t < 3; t++) begin
            bus(1'b1, EMC_OFF_SPACE, {24'h0, {4{2'(t)}}});
            for (int k = 0; k < 8; k++) begin
                logic w, sel, sd;
                logic [1:0] sp;
                rnd = xs(rnd);
                w = k[0];
                sp = 2'(k >> 1);
                sel = rnd[4];
                sd = (t == 1);
                dly <= (t == 0) ? rnd[3:0] & 4'h7 : 4'h0;
                bus(1'b1, EMC_OFF_CTRL, ctl({sel, 3'h1}, 2'h0));
                pulse_clear();
                bus(1'b1, EMC_OFF_ACCESS, {26'h0, 1'b1, w, 2'h0, sp});
                for (n = 0; n < 30 && cs_pin === 4'hF; n++)
                    @(posedge clk_i);
                for (n = 0; n < 200 && cs_pin !== 4'hF; n++)
                    @(posedge clk_i);
                repeat (2) @(posedge clk_i);
                chk("chip_select", 32'(4'h1 << sp), 32'(cs_seen));
                chk("strobes", 32'({t == 2 && sp == 3 && !w, w, sd || !w,
                    sd || (t == 2 && !sel) || !w}), 32'(low_seen));
                chk("strobe_len", 1,
                    32'(t != 0 || (scyc >= 4 && scyc > 8'(dly))));
            end
        end
        bus(1'b1, EMC_OFF_SPACE, 32'h0);
        hold_cmd <= 1'b1;
        for (n = 0; n < 20 && host_bus_hold_grant_o !== 1'b1; n++)
            @(posedge clk_i);
        chk("grant", 1, 32'(host_bus_hold_grant_o));
        chk("floated", 0, 32'(strobes_oe_o));
        pulse_clear();
        bus(1'b1, EMC_OFF_ACCESS, 32'h21);
        for (n = 0; n < 10 && memif_bus_request_out_o !== 1'b1; n++)
            @(posedge clk_i);
        chk("bus_request", 1, 32'(memif_bus_request_out_o));
        chk("no_select", 0, 32'(cs_seen));
        hold_cmd <= 1'b0;
        for (n = 0; n < 40 && cs_pin === 4'hF; n++) @(posedge clk_i);
        chk("grant_off", 32'hD, 32'({host_bus_hold_grant_o, cs_pin}));
        for (int i = 0; i < 4; i++) begin
            // self-refresh, then general output use
            bus(1'b1, EMC_OFF_CTRL,
                ctl(i < 2 ? 4'({i == 0, 1'b1}) : 4'({i == 2, 2'b0}), 2'h0));
            for (n = 0; n < 8 && sdram_clock_enable_out_o !== (i % 3 != 0);
                 n++) begin
                @(posedge clk_i);
            end
            chk("clock_enable", 32'(i % 3 != 0),
                32'(sdram_clock_enable_out_o));
        end
        finish_test();
    end
endmodule
`default_nettype wire
